// *** scan_pkg.sv ***
// constants, types and state record of the scan TAP master
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package scan_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CMD  = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CFG  = 8'h08;
	localparam logic [7:0] ADDR_DISC = 8'h0C;
	localparam logic [7:0] ADDR_LEN  = 8'h10;
	localparam logic [7:0] ADDR_OUTQ = 8'h14;
	localparam logic [7:0] ADDR_INQ  = 8'h18;

	// field positions
	localparam int CMD_CLS_LSB        = 0;
	localparam int CMD_IR_BIT         = 2;
	localparam int CMD_SOFT_RESET_BIT = 7;
	localparam int STAT_BUSY_BIT      = 0;
	localparam int STAT_OUTFULL_BIT   = 6;
	localparam int STAT_INEMPTY_BIT   = 7;
	localparam int CFG_DELAY_LSB      = 0;
	localparam int CFG_LOOP_LSB       = 4;
	localparam int CFG_DISC_BIT       = 6;
	localparam int DISC_TMS_BIT       = 0;
	localparam int DISC_TDO_BIT       = 1;
	localparam int DISC_TRST_BIT      = 2;
	localparam int DISC_TCK_BIT       = 3;
	localparam int DISC_TDI_BIT       = 4;

	// sizes and cycle counts
	localparam logic [2:0] FIFO_DEPTH  = 3'h4;
	localparam logic [3:0] TCK_RISE_AT = 4'h7;
	localparam logic [3:0] TCK_FALL_AT = 4'hF;
	localparam int         TLR_LIMIT_CYCLES = 72;

	// values after reset
	localparam logic [3:0]  RST_DCTL  = 4'h7;
	localparam logic [3:0]  RST_DELAY = 4'h0;
	localparam logic [15:0] RST_LEN   = 16'h0000;

	typedef enum logic [1:0] {
		SC_NORMAL, SC_IN_ONLY, SC_OUT_ONLY, SC_RECIRC
	} scan_class_t;

	typedef enum logic [1:0] {
		LB_NONE, LB_OUTQ, LB_TMS, LB_SPARE
	} loop_mode_t;

	typedef enum logic [2:0] {
		TS_TLR, TS_RTI, TS_SEL_DR, TS_SEL_IR,
		TS_CAPTURE, TS_SHIFT, TS_EXIT1, TS_UPDATE
	} tap_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdo;
		logic trst;
	} tap_pins_t;

	localparam tap_pins_t RST_PINS = '{tck: 1'b0, tms: 1'b1,
		tdo: 1'b1, trst: 1'b1};

	typedef logic [3:0][7:0] fifo_mem_t;

	typedef struct packed {
		logic        aAct;
		logic        aWrite;
		logic [7:0]  aAddr;
		logic        rdDone;
		logic [31:0] rdata;
		scan_class_t cls;
		logic        isIr;
		logic [15:0] lenBits;
		logic [3:0]  returnDelayCount;
		loop_mode_t  loop;
		logic        cfgDisc;
		logic [3:0]  dctl;
		logic        cmdActive;
		logic        shDone;
		tap_state_t  tapSt;
		logic [3:0]  div;
		logic        tck;
		logic        tms;
		logic        tdo;
		logic [15:0] txLeft;
		logic [7:0]  txByte;
		logic [2:0]  txBitCnt;
		logic        txBit;
		logic        rxOn;
		logic [3:0]  rxSkip;
		logic [15:0] rxLeft;
		logic [7:0]  asm;
		logic [2:0]  asmCnt;
		fifo_mem_t   outQ;
		logic [1:0]  outWr;
		logic [1:0]  outRd;
		logic [2:0]  outCnt;
		fifo_mem_t   inQ;
		logic [1:0]  inWr;
		logic [1:0]  inRd;
		logic [2:0]  inCnt;
		logic [2:0]  tdiSync;
		logic        tdiVal;
		tap_pins_t   pins;
		logic        outFull;
		logic        inEmpty;
	} master_state_t;

endpackage : scan_pkg

// *** scan_tap_master.sv ***
// scan TAP master: scan FIFOs, scan classes, loopback, discrete, reset
`timescale 1ns/1ns
module scan_tap_master (
	// reference clock (TCK source), reset, freeze
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [31:0]        hrdata,
	output logic               hresp,
	// TAP pins
	input  wire logic          tdi,
	output scan_pkg::tap_pins_t tapPins,
	// buffer status
	output logic               outFifoFullFlag,
	output logic               inFifoEmptyFlag
);

	//------------------------------------------------------------------
	// state, helpers
	//------------------------------------------------------------------
	scan_pkg::master_state_t st_r;
	scan_pkg::master_state_t st_nxt;
	logic       dataWr;
	logic       dataRd;
	logic       busHold;
	logic       riseNow;
	logic       fallNow;
	logic       txUse;
	logic       stall;
	logic       bitV;
	logic [7:0] byteV;
	logic [7:0] inByte;
	logic       pushOut;
	logic       popOut;
	logic       pushIn;
	logic       popIn;
	logic       clrOut;
	logic       softRst;

	// reset image shared by pin reset and soft reset
	function automatic scan_pkg::master_state_t rst_state();
		scan_pkg::master_state_t s;
		s = '0;
		s.tms = 1'b1;
		s.tdo = 1'b1;
		s.dctl = scan_pkg::RST_DCTL;
		s.returnDelayCount = scan_pkg::RST_DELAY;
		s.lenBits = scan_pkg::RST_LEN;
		s.pins = scan_pkg::RST_PINS;
		s.inEmpty = 1'b1;
		return s;
	endfunction : rst_state

	// target TAP walk as seen from our TMS
	function automatic scan_pkg::tap_state_t next_tap(
		input scan_pkg::tap_state_t cur, input logic tms);
		scan_pkg::tap_state_t nx;
		nx = cur;
		unique case (cur)
			scan_pkg::TS_TLR:
				nx = tms ? scan_pkg::TS_TLR : scan_pkg::TS_RTI;
			scan_pkg::TS_RTI:
				nx = tms ? scan_pkg::TS_SEL_DR : scan_pkg::TS_RTI;
			scan_pkg::TS_SEL_DR:
				nx = tms ? scan_pkg::TS_SEL_IR : scan_pkg::TS_CAPTURE;
			scan_pkg::TS_SEL_IR:
				nx = tms ? scan_pkg::TS_TLR : scan_pkg::TS_CAPTURE;
			scan_pkg::TS_CAPTURE:
				nx = tms ? scan_pkg::TS_EXIT1 : scan_pkg::TS_SHIFT;
			scan_pkg::TS_SHIFT:
				nx = tms ? scan_pkg::TS_EXIT1 : scan_pkg::TS_SHIFT;
			scan_pkg::TS_EXIT1:
				nx = tms ? scan_pkg::TS_UPDATE : scan_pkg::TS_SHIFT;
			scan_pkg::TS_UPDATE:
				nx = tms ? scan_pkg::TS_SEL_DR : scan_pkg::TS_RTI;
		endcase
		return nx;
	endfunction : next_tap

	// pin source: discrete register, loopback or generator
	function automatic scan_pkg::tap_pins_t pin_mux(
		input scan_pkg::master_state_t s);
		scan_pkg::tap_pins_t p;
		p = scan_pkg::RST_PINS;
		p.tck = s.tck;
		if (s.cfgDisc) begin
			p.tck = s.dctl[scan_pkg::DISC_TCK_BIT];
			p.tms = s.dctl[scan_pkg::DISC_TMS_BIT];
			p.tdo = s.dctl[scan_pkg::DISC_TDO_BIT];
			p.trst = s.dctl[scan_pkg::DISC_TRST_BIT];
		end else if (s.loop == scan_pkg::LB_NONE) begin
			p.tms = s.tms;
			p.tdo = s.tdo;
		end // loopback keeps tms/tdo high
		return p;
	endfunction : pin_mux

	// register read image
	function automatic logic [31:0] read_word(
		input scan_pkg::master_state_t s);
		logic [31:0] w;
		w = '0;
		unique case (s.aAddr)
			scan_pkg::ADDR_CMD: begin
				w[scan_pkg::CMD_CLS_LSB +: 2] = s.cls;
				w[scan_pkg::CMD_IR_BIT] = s.isIr;
			end
			scan_pkg::ADDR_STAT: begin
				w[scan_pkg::STAT_BUSY_BIT] = s.cmdActive;
				w[scan_pkg::STAT_OUTFULL_BIT] = s.outFull;
				w[scan_pkg::STAT_INEMPTY_BIT] = s.inEmpty;
			end
			scan_pkg::ADDR_CFG: begin
				w[scan_pkg::CFG_DELAY_LSB +: 4] = s.returnDelayCount;
				w[scan_pkg::CFG_LOOP_LSB +: 2] = s.loop;
				w[scan_pkg::CFG_DISC_BIT] = s.cfgDisc;
			end
			scan_pkg::ADDR_DISC: begin
				w[3:0] = s.dctl;
				w[scan_pkg::DISC_TDI_BIT] = s.tdiVal;
			end
			scan_pkg::ADDR_LEN: w[15:0] = s.lenBits;
			scan_pkg::ADDR_INQ: w[7:0] = s.inQ[s.inRd];
			default: w = '0;
		endcase
		return w;
	endfunction : read_word

	//------------------------------------------------------------------
	// bus handshake and TCK timing
	//------------------------------------------------------------------
	// reads take one wait state so hrdata comes from a flop
	assign dataWr = st_r.aAct && st_r.aWrite;
	assign dataRd = st_r.aAct && !st_r.aWrite;
	assign busHold = (dataWr && st_r.aAddr == scan_pkg::ADDR_OUTQ
		&& st_r.outCnt == scan_pkg::FIFO_DEPTH)
		|| (dataRd && !st_r.rdDone);
	assign hreadyout = !busHold;
	assign hrdata = st_r.rdata;
	assign hresp = 1'b0;
	assign tapPins = st_r.pins;
	assign outFifoFullFlag = st_r.outFull;
	assign inFifoEmptyFlag = st_r.inEmpty;
	assign riseNow = st_r.div == scan_pkg::TCK_RISE_AT;
	assign fallNow = st_r.div == scan_pkg::TCK_FALL_AT;
	assign txUse = st_r.cls == scan_pkg::SC_NORMAL
		|| st_r.cls == scan_pkg::SC_OUT_ONLY;
	// gate TCK rather than lose a bit when a FIFO runs dry or full
	assign stall = st_r.cmdActive && ((fallNow
		&& st_r.tapSt == scan_pkg::TS_SHIFT && txUse
		&& st_r.txBitCnt == 3'h0 && st_r.outCnt == 3'h0)
		|| (riseNow && st_r.rxOn
		&& st_r.inCnt == scan_pkg::FIFO_DEPTH));

	//------------------------------------------------------------------
	// next state
	//------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		bitV = 1'b0;
		byteV = '0;
		inByte = '0;
		pushOut = 1'b0;
		popOut = 1'b0;
		pushIn = 1'b0;
		popIn = 1'b0;
		clrOut = 1'b0;
		softRst = 1'b0;
		// three-stage TDI synchroniser, change taken when 2 and 3 agree
		st_nxt.tdiSync = {st_r.tdiSync[1:0], tdi};
		if (st_r.tdiSync[1] == st_r.tdiSync[2])
			st_nxt.tdiVal = st_r.tdiSync[2];
		// read capture; an empty incoming FIFO keeps the wait going
		if (dataRd && !st_r.rdDone && !(st_r.aAddr == scan_pkg::ADDR_INQ
			&& st_r.inCnt == 3'h0)) begin
			st_nxt.rdDone = 1'b1;
			st_nxt.rdata = read_word(st_r);
			popIn = st_r.aAddr == scan_pkg::ADDR_INQ;
		end
		if (st_r.aAct && !busHold)
			st_nxt.aAct = 1'b0;
		// register writes take effect when the data phase ends
		if (dataWr && !busHold) begin
			unique case (st_r.aAddr)
				scan_pkg::ADDR_CMD: begin
					if (hwdata[scan_pkg::CMD_SOFT_RESET_BIT]) begin
						softRst = 1'b1;
					end else if (!st_r.cfgDisc && !st_r.cmdActive
						&& st_r.lenBits != 16'h0000) begin
						st_nxt.cls = scan_pkg::scan_class_t'(
							hwdata[scan_pkg::CMD_CLS_LSB +: 2]);
						st_nxt.isIr = hwdata[scan_pkg::CMD_IR_BIT];
						st_nxt.cmdActive = 1'b1;
						st_nxt.shDone = 1'b0;
						st_nxt.txLeft = st_r.lenBits;
						st_nxt.txBitCnt = 3'h0;
						clrOut = 1'b1;
					end
				end
				scan_pkg::ADDR_CFG: begin
					st_nxt.returnDelayCount =
						hwdata[scan_pkg::CFG_DELAY_LSB +: 4];
					st_nxt.loop = scan_pkg::loop_mode_t'(
						hwdata[scan_pkg::CFG_LOOP_LSB +: 2]);
					st_nxt.cfgDisc = hwdata[scan_pkg::CFG_DISC_BIT];
				end
				scan_pkg::ADDR_DISC: st_nxt.dctl = hwdata[3:0];
				scan_pkg::ADDR_LEN: st_nxt.lenBits = hwdata[15:0];
				scan_pkg::ADDR_OUTQ: pushOut = 1'b1;
				default: ;
			endcase
		end
		// TCK divider, reference clock over 16
		if (!stall) begin
			st_nxt.div = 4'(st_r.div + 4'h1);
			if (riseNow)
				st_nxt.tck = 1'b1;
			if (fallNow)
				st_nxt.tck = 1'b0;
		end
		// falling edge: TMS and TDO for the next rising edge
		if (!stall && fallNow) begin
			st_nxt.tdo = 1'b1;
			if (!st_r.cmdActive) begin
				// idle sits in Run-Test/Idle; from any other state it walks back to, and sits in, Test-Logic-Reset
				st_nxt.tms = st_r.tapSt != scan_pkg::TS_RTI;
			end else begin
				unique case (st_r.tapSt)
					scan_pkg::TS_TLR: st_nxt.tms = 1'b0;
					scan_pkg::TS_RTI: st_nxt.tms = !st_r.shDone;
					scan_pkg::TS_SEL_DR: st_nxt.tms = st_r.isIr;
					scan_pkg::TS_SEL_IR: st_nxt.tms = 1'b0;
					scan_pkg::TS_CAPTURE: st_nxt.tms = 1'b0;
					scan_pkg::TS_EXIT1: st_nxt.tms = 1'b1;
					// target latches the update on this edge
					scan_pkg::TS_UPDATE: st_nxt.tms = 1'b0;
					scan_pkg::TS_SHIFT: begin
						if (txUse) begin
							byteV = st_r.txByte;
							if (st_r.txBitCnt == 3'h0) begin
								byteV = st_r.outQ[st_r.outRd];
								popOut = 1'b1;
							end
							bitV = byteV[0];
							st_nxt.txByte = {1'b0, byteV[7:1]};
							st_nxt.txBitCnt = 3'(st_r.txBitCnt + 3'h1);
						end else if (st_r.cls == scan_pkg::SC_RECIRC) begin
							bitV = st_r.tdiVal;
						end else begin
							bitV = 1'b1;
						end
						st_nxt.txBit = bitV;
						st_nxt.tdo = bitV;
						st_nxt.tms = st_r.txLeft == 16'h0001;
						st_nxt.txLeft = 16'(st_r.txLeft - 16'h0001);
					end
				endcase
			end
		end
		// rising edge: follow the target and sample the return data
		if (!stall && riseNow) begin
			st_nxt.tapSt = next_tap(st_r.tapSt, st_r.tms);
			if (st_r.cmdActive && !st_r.tms
				&& st_r.tapSt == scan_pkg::TS_CAPTURE) begin
				st_nxt.rxOn = st_r.cls != scan_pkg::SC_OUT_ONLY;
				st_nxt.rxSkip = st_r.returnDelayCount;
				st_nxt.rxLeft = st_r.lenBits;
				st_nxt.asm = '0;
				st_nxt.asmCnt = 3'h0;
			end
			if (st_r.cmdActive && !st_r.tms
				&& st_r.tapSt == scan_pkg::TS_UPDATE)
				st_nxt.shDone = 1'b1;
			if (st_r.rxOn) begin
				if (st_r.rxSkip != 4'h0) begin
					st_nxt.rxSkip = 4'(st_r.rxSkip - 4'h1);
				end else begin
					if (st_r.loop == scan_pkg::LB_OUTQ)
						bitV = st_r.txBit;
					else if (st_r.loop == scan_pkg::LB_TMS)
						bitV = st_r.tms;
					else
						bitV = st_r.tdiVal;
					byteV = st_r.asm;
					byteV[st_r.asmCnt] = bitV;
					st_nxt.asm = byteV;
					st_nxt.asmCnt = 3'(st_r.asmCnt + 3'h1);
					st_nxt.rxLeft = 16'(st_r.rxLeft - 16'h0001);
					if (st_r.asmCnt == 3'h7 || st_r.rxLeft == 16'h0001) begin
						pushIn = 1'b1;
						inByte = byteV;
						st_nxt.asm = '0;
						st_nxt.asmCnt = 3'h0;
					end
					if (st_r.rxLeft == 16'h0001)
						st_nxt.rxOn = 1'b0;
				end
			end
		end
		// command ends back in Run-Test/Idle once all bits are in
		if (st_r.cmdActive && st_r.shDone && !st_r.rxOn
			&& st_r.tapSt == scan_pkg::TS_RTI)
			st_nxt.cmdActive = 1'b0;
		// outgoing FIFO
		if (clrOut) begin
			st_nxt.outWr = 2'h0;
			st_nxt.outRd = 2'h0;
			st_nxt.outCnt = 3'h0;
		end else begin
			if (pushOut) begin
				st_nxt.outQ[st_r.outWr] = hwdata[7:0];
				st_nxt.outWr = 2'(st_r.outWr + 2'h1);
			end
			if (popOut)
				st_nxt.outRd = 2'(st_r.outRd + 2'h1);
			if (pushOut && !popOut)
				st_nxt.outCnt = 3'(st_r.outCnt + 3'h1);
			else if (popOut && !pushOut)
				st_nxt.outCnt = 3'(st_r.outCnt - 3'h1);
		end
		// incoming FIFO
		if (pushIn) begin
			st_nxt.inQ[st_r.inWr] = inByte;
			st_nxt.inWr = 2'(st_r.inWr + 2'h1);
		end
		if (popIn)
			st_nxt.inRd = 2'(st_r.inRd + 2'h1);
		if (pushIn && !popIn)
			st_nxt.inCnt = 3'(st_r.inCnt + 3'h1);
		else if (popIn && !pushIn)
			st_nxt.inCnt = 3'(st_r.inCnt - 3'h1);
		// discrete mode stops any command in flight
		if (st_nxt.cfgDisc) begin
			st_nxt.cmdActive = 1'b0;
			st_nxt.rxOn = 1'b0;
		end
		// soft reset loads the same image as the reset pin
		if (softRst)
			st_nxt = rst_state();
		// address phase; upper address bits are not decoded
		if (hsel && htrans[1] && hready) begin
			st_nxt.aAct = 1'b1;
			st_nxt.aWrite = hwrite;
			st_nxt.aAddr = haddr[7:0];
			st_nxt.rdDone = 1'b0;
		end
		st_nxt.pins = pin_mux(st_nxt);
		st_nxt.outFull = st_nxt.outCnt == scan_pkg::FIFO_DEPTH;
		st_nxt.inEmpty = st_nxt.inCnt == 3'h0;
	end

	// state register; rst and soft reset share one image
	always_ff @(posedge clk) begin
		if (rst)
			st_r <= rst_state();
		else if (ce)
			st_r <= st_nxt;
	end

	//------------------------------------------------------------------
	// assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_out_full_hold: assert property (dataWr
		&& st_r.aAddr == scan_pkg::ADDR_OUTQ && outFifoFullFlag
		|-> !hreadyout ##1 (st_r.outCnt == 3'h4 || $past(popOut)))
		else $error("write to full outgoing FIFO not held");
	a_in_empty_hold: assert property (dataRd
		&& st_r.aAddr == scan_pkg::ADDR_INQ && inFifoEmptyFlag
		&& !st_r.rdDone
		|-> !hreadyout && st_r.inCnt == 3'h0)
		else $error("read of empty incoming FIFO not held");
	a_cmd_clears_out: assert property (ce && dataWr && !busHold
		&& st_r.aAddr == scan_pkg::ADDR_CMD && !hwdata[7]
		&& !st_r.cfgDisc && !st_r.cmdActive && st_r.lenBits != 16'h0000
		|=> st_r.cmdActive && st_r.outCnt == 3'h0 && !outFifoFullFlag)
		else $error("command start did not clear outgoing FIFO");
	a_in_only_tdo: assert property (st_r.cmdActive
		&& st_r.cls == scan_pkg::SC_IN_ONLY |-> st_r.tdo)
		else $error("TDO not high in input-only scan");
	a_recirc_tdo: assert property (ce && st_r.cmdActive && fallNow
		&& !stall && st_r.cls == scan_pkg::SC_RECIRC
		&& st_r.tapSt == scan_pkg::TS_SHIFT
		|=> st_r.tdo == $past(st_r.tdiVal))
		else $error("recirculated bit differs from TDI");
	a_disc_pins: assert property (st_r.cfgDisc |-> !st_r.cmdActive
		&& tapPins.tdo == st_r.dctl[1] && tapPins.tms == st_r.dctl[0])
		else $error("discrete mode pins or command wrong");
	a_loop_pins_high: assert property (!st_r.cfgDisc
		&& st_r.loop != scan_pkg::LB_NONE
		|-> tapPins.tms && tapPins.tdo && tapPins.trst)
		else $error("loopback did not hold target pins high");
	a_out_only_no_rx: assert property (st_r.cmdActive
		&& st_r.cls == scan_pkg::SC_OUT_ONLY |-> !st_r.rxOn
		##1 $stable(st_r.inWr))
		else $error("output-only scan filled incoming FIFO");
	a_rx_skip: assert property (ce && riseNow && !stall
		&& st_r.rxOn && st_r.rxSkip != 4'h0
		|=> st_r.asmCnt == $past(st_r.asmCnt)
		&& st_r.rxLeft == $past(st_r.rxLeft))
		else $error("TDI sampled during return delay");
	a_reset_state: assert property ($fell(rst) |-> tapPins.tms
		&& tapPins.tdo && tapPins.trst && !outFifoFullFlag
		&& inFifoEmptyFlag && !st_r.cfgDisc
		&& st_r.tapSt == scan_pkg::TS_TLR)
		else $error("state after reset wrong");
	a_tck_first_rise: assert property (disable iff (rst || !ce)
		$fell(rst) |-> !tapPins.tck [*8] ##1 tapPins.tck)
		else $error("first TCK rise not 8 cycles after reset");
	a_soft_reset: assert property (ce && dataWr && !busHold
		&& st_r.aAddr == scan_pkg::ADDR_CMD && hwdata[7]
		|=> st_r.outCnt == 3'h0 && st_r.inCnt == 3'h0 && !st_r.cfgDisc
		&& st_r.tapSt == scan_pkg::TS_TLR && !st_r.cmdActive)
		else $error("soft reset differs from reset");

	c_cmd_done: cover property ($fell(st_r.cmdActive) && !st_r.cfgDisc);
	c_out_full: cover property (dataWr && busHold && outFifoFullFlag);
	c_in_read: cover property (popIn && st_r.inCnt == 3'h1);
	c_loop_tms: cover property (pushIn && st_r.loop == scan_pkg::LB_TMS);

endmodule : scan_tap_master

// *** scan_target_model.sv ***
// scan target model: one-bit bypass path behind a TAP controller
`timescale 1ns/1ns
module scan_target_model (
	// TAP from the master
	input  scan_pkg::tap_pins_t tapPins,
	// serial return to the master
	output logic                tdi
);
	logic [3:0] st    = 4'h0;
	logic       sh    = 1'b0;
	logic       curIr = 1'b0;
	logic       tdiR  = 1'b1;
	// next state for tms low and tms high, sixteen states
	localparam logic [3:0] NX0 [16] = '{1,1,3,4,4,6,6,4,1,10,11,11,13,13,11,1};
	localparam logic [3:0] NX1 [16] = '{0,2,9,5,5,8,7,8,2,0,12,12,15,14,15,2};

	assign tdi = tdiR;

	// state walk, capture and shift on the rising edge
	always @(posedge tapPins.tck) begin
		if (st == 4'h3 || st == 4'hA)
			sh <= 1'b0;
		if (st == 4'h4 || st == 4'hB)
			sh <= tapPins.tdo;
		st <= tapPins.tms ? NX1[st] : NX0[st];
	end

	// drive on falling edge; outside shift no stale level is shown
	always @(negedge tapPins.tck) begin
		if (st == 4'hF)
			curIr <= sh;
		if (st == 4'h4 || st == 4'hB)
			tdiR <= sh;
		else
			tdiR <= ~tdiR;
	end
endmodule : scan_target_model

// *** scan_tap_master_buffers_reset_test.sv ***
// self-checking bench for the scan TAP master
`timescale 1ns/1ns
module scan_tap_master_buffers_reset_test;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [31:0]         haddr = 32'h0;
	logic [31:0]         hwdata = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic                hready;
	logic                hreadyout;
	logic [31:0]         hrdata;
	logic                hresp;
	logic [31:0]         rdv;
	logic                tdi;
	logic                outFull;
	logic                inEmpty;
	logic [3:0]          hiMask = 4'h0;
	logic                pt = 1'b0;
	scan_pkg::tap_pins_t tapPins;
	int                  badCount = 0;
	int                  totalChecks = 0;
	int                  n = 0;
	int                  k = 0;
	int                  f = 0;
	// register reads after reset: offset, expected, mask
	localparam logic [71:0] ROWS [6] = '{72'h04_00000080_000000FF,
		72'h08_00000000_0000007F, 72'h0C_00000007_0000000F,
		72'h10_00000000_0000FFFF, 72'h1C_00000000_FFFFFFFF,
		72'h20_00000000_FFFFFFFF};

	always #20 clk = ~clk;
	assign hready = hreadyout;

	scan_tap_master i_scan_tap_master (.clk(clk), .rst(rst), .ce(1'b1),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tdi(tdi),
		.tapPins(tapPins), .outFifoFullFlag(outFull),
		.inFifoEmptyFlag(inEmpty));
	scan_target_model i_scan_target_model (.tapPins(tapPins), .tdi(tdi));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		totalChecks++;
		if (s !== e) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic summarize;
		if (badCount == 0 && totalChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// one word transfer; waits on the slave's own ready
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask : bus

	task automatic regs;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ROWS[i][71:64], 32'h0);
			chk("reg", rdv & ROWS[i][31:0], ROWS[i][63:32]);
		end
	endtask : regs

	// config, length and command first, then outgoing bytes, then poll busy
	task automatic scan(input logic [7:0] cfg, cmd, input logic [15:0] len,
		dat, input int nb, input logic [3:0] msk);
		bus(1'b1, scan_pkg::ADDR_CFG, {24'h0, cfg});
		bus(1'b1, scan_pkg::ADDR_LEN, {16'h0, len});
		bus(1'b1, scan_pkg::ADDR_CMD, {24'h0, cmd});
		hiMask = msk;
		for (int i = 0; i < nb; i++)
			bus(1'b1, scan_pkg::ADDR_OUTQ, {24'h0, dat[8*i +: 8]});
		do bus(1'b0, scan_pkg::ADDR_STAT, 32'h0); while (rdv[0] !== 1'b0);
		hiMask = 4'h0;
	endtask : scan

	// pins that must stay high during the running command
	always @(posedge clk) begin
		if (hiMask !== 4'h0)
			chk("tap high", {28'h0, tapPins & hiMask},
				{28'h0, hiMask});
	end

	// hang guard: far beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		badCount++;
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		chk("reset pins", {29'h0, tapPins[2:0]}, 32'h7);
		rst <= 1'b0;
		while (k < 5) begin
			@(posedge clk);
			n++;
			if (tapPins.tck && !pt)
				k++;
			if (k == 1 && f == 0)
				f = n;
			pt = tapPins.tck;
		end
		chk("tck period", n - f, 64);
		chk("tlr bound", {31'h0, n <= 73}, 32'h1);
		chk("flags", {30'h0, outFull, inEmpty}, 32'h1);
		chk("hresp", {31'h0, hresp}, 32'h0);
		regs();
		// bypass target returns captured zero then the data
		scan(8'h00, 8'h00, 16'h000C, 16'h0CA5, 2, 4'h0);
		chk("in flag", {31'h0, inEmpty}, 32'h0);
		bus(1'b0, scan_pkg::ADDR_INQ, 32'h0);
		chk("in byte0", rdv & 32'hFF, 32'h4A);
		bus(1'b0, scan_pkg::ADDR_INQ, 32'h0);
		chk("in byte1", rdv & 32'hFF, 32'h09);
		@(posedge clk);
		chk("in empty", {31'h0, inEmpty}, 32'h1);
		// input-only at two return delays
		for (int d = 0; d < 2; d++) begin
			scan({4'h0, 4'(d)}, 8'h01, 16'h0008, 16'h0, 0, 4'h2);
			bus(1'b0, scan_pkg::ADDR_INQ, 32'h0);
			chk("delay", rdv & 32'hFF, d ? 32'h7F : 32'hFE);
		end
		scan(8'h00, 8'h02, 16'h0008, 16'h0055, 1, 4'h0);
		@(posedge clk);
		chk("out only", {31'h0, inEmpty}, 32'h1);
		// four bytes fill the outgoing FIFO, the fifth waits for a pop
		bus(1'b1, scan_pkg::ADDR_LEN, 32'h28);
		bus(1'b1, scan_pkg::ADDR_CMD, 32'h2);
		for (int i = 0; i < 4; i++)
			bus(1'b1, scan_pkg::ADDR_OUTQ, 32'h5A);
		@(posedge clk);
		chk("out full", {31'h0, outFull}, 32'h1);
		bus(1'b0, scan_pkg::ADDR_STAT, 32'h0);
		chk("stat full", {31'h0, rdv[6]}, 32'h1);
		bus(1'b1, scan_pkg::ADDR_OUTQ, 32'h5A);
		do bus(1'b0, scan_pkg::ADDR_STAT, 32'h0); while (rdv[0] !== 1'b0);
		chk("out only long", {31'h0, inEmpty}, 32'h1);
		// recirculate on the IR path; the read waits on an empty FIFO
		bus(1'b1, scan_pkg::ADDR_LEN, 32'h8);
		bus(1'b1, scan_pkg::ADDR_CMD, 32'h7);
		bus(1'b0, scan_pkg::ADDR_INQ, 32'h0);
		chk("recirc", rdv & 32'h55, 32'h0);
		do bus(1'b0, scan_pkg::ADDR_STAT, 32'h0); while (rdv[0] !== 1'b0);
		// loopback from outgoing FIFO, then from TMS generator
		for (int m = 1; m < 3; m++) begin
			scan({2'h0, 2'(m), 4'h0}, 8'h00, 16'h0008, 16'h003C, 1, 4'h7);
			bus(1'b0, scan_pkg::ADDR_INQ, 32'h0);
			chk("loop", rdv & 32'hFF, m == 1 ? 32'h3C : 32'h80);
		end
		// discrete mode drives pins and refuses commands
		bus(1'b1, scan_pkg::ADDR_CFG, 32'h40);
		bus(1'b1, scan_pkg::ADDR_DISC, 32'h08);
		repeat (3) @(posedge clk);
		chk("disc pins", {28'h0, tapPins}, 32'h8);
		bus(1'b0, scan_pkg::ADDR_DISC, 32'h0);
		chk("disc tdi", {31'h0, rdv[4]}, {31'h0, tdi});
		bus(1'b1, scan_pkg::ADDR_LEN, 32'h8);
		bus(1'b1, scan_pkg::ADDR_CMD, 32'h0);
		bus(1'b0, scan_pkg::ADDR_STAT, 32'h0);
		chk("disc busy", {31'h0, rdv[0]}, 32'h0);
		// soft reset must match the hardware reset image
		bus(1'b1, scan_pkg::ADDR_CMD, 32'h80);
		regs();
		chk("soft pins", {29'h0, tapPins[2:0]}, 32'h7);
		chk("soft flags", {30'h0, outFull, inEmpty}, 32'h1);
		summarize();
	end
endmodule : scan_tap_master_buffers_reset_test
